// file: rtl/abd_datapath.sv
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "abd_regs.svh"
// Summary of operation
// - Add literal to accumulator, update C, DC, Z
// - Add file byte to accumulator, update flags
// - Destination bit 0 accumulator, 1 file byte
// - AND with file byte, only Z changes
// - AND literal into accumulator, only Z changes
// - Clear chosen file bit, flags untouched
// - Set chosen file bit, flags untouched
// - Bit one: discard next, two cycles, flags kept
// - Bit zero: discard next, two cycles, flags kept
module abd_datapath (
  input  wire logic                   CLOCK_I,           // Core clock, 25 MHz
  input  wire logic                   RST_N_I,           // Synchronous reset, active low
  input  wire logic [`ABD_ADDR_W-1:0] AVS_ADDRESS_I,     // Word address
  input  wire logic                   AVS_READ_I,        // Read request
  input  wire logic                   AVS_WRITE_I,       // Write request
  input  wire logic [31:0]            AVS_WRITEDATA_I,   // Write data
  input  wire logic [3:0]             AVS_BYTEENABLE_I,  // Byte lanes
  output logic      [31:0]            AVS_READDATA_O,    // Read data
  output logic                        AVS_WAITREQUEST_O, // Low for the answer cycle
  output logic                        BUSY_O,            // Instruction in progress
  output logic                        SKIP_O             // Next instruction discarded
);
  abd_mem_if mif ();  // Link to the file byte store

  abd_file_mem u_mem (
    .clk_i   (CLOCK_I),
    .rst_n_i (RST_N_I),
    .port_m  (mif.mem)
  );

  // Mask with a single bit set at the given index
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  // True when a byte is all zero
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  // Sum with nibble carry and word carry: {dc, c, sum}
  function automatic logic [9:0] add_flags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b};
    n = {1'b0, a[`ABD_NIB_F]} + {1'b0, b[`ABD_NIB_F]};
    add_flags = {n[`ABD_NIB_CARRY], s};
  endfunction

  // State
  abd_pkg::abd_ex_state_t  ex_state_r;    // Execution sequence
  abd_pkg::abd_ex_state_t  ex_state_nxt;  // Its next value
  abd_pkg::abd_bus_state_t bus_state_r;   // Bus answer sequence
  abd_pkg::abd_bus_state_t bus_state_nxt; // Its next value
  logic [7:0]              acc_r;         // Accumulator
  logic                    c_r;           // Word overflow flag
  logic                    dc_r;          // nibble_overflow_flag
  logic                    z_r;           // Result null flag
  logic [`ABD_INSTR_W-1:0] instr_r;       // Instruction being executed
  logic                    skip_cnt_r;    // Clock within the discarded slot
  logic                    last_skip_r;   // Last instruction discarded its successor
  logic                    skip_r;        // Discard pulse
  logic                    busy_r;        // Busy level
  logic                    waitreq_r;     // Waitrequest
  logic [31:0]             rdata_r;       // Read data

  // Instruction decode
  abd_pkg::abd_op_t op;                          // Decoded operation
  wire [7:0]              lit       = instr_r[`ABD_LIT_F];
  wire [`ABD_FADDR_W-1:0] faddr     = instr_r[`ABD_FADDR_F];
  wire                    dest_file = instr_r[`ABD_D_BIT];
  wire [2:0]              bit_idx   = instr_r[`ABD_BIT_F];

  // Codes outside the supported set decode as no_operation
  assign op = (instr_r[`ABD_LITADD_F] == `ABD_PAT_ADD_LIT) ?
                abd_pkg::OP_ADD_LITERAL_TO_ACCUMULATOR :
              (instr_r[`ABD_BYTEOP_F] == `ABD_PAT_AND_LIT) ?
                abd_pkg::OP_AND_LITERAL_WITH_ACCUMULATOR :
              (instr_r[`ABD_BYTEOP_F] == `ABD_PAT_ADD_FILE) ?
                abd_pkg::OP_ADD_ACCUMULATOR_AND_FILE :
              (instr_r[`ABD_BYTEOP_F] == `ABD_PAT_AND_FILE) ?
                abd_pkg::OP_AND_ACCUMULATOR_WITH_FILE :
              (instr_r[`ABD_BITOP_F] == `ABD_PAT_BIT_CLR) ? abd_pkg::OP_FILE_BIT_CLEAR :
              (instr_r[`ABD_BITOP_F] == `ABD_PAT_BIT_SET) ? abd_pkg::OP_FILE_BIT_SET :
              (instr_r[`ABD_BITOP_F] == `ABD_PAT_TST_ZERO) ? abd_pkg::OP_TEST_SKIP_IF_ZERO :
              (instr_r[`ABD_BITOP_F] == `ABD_PAT_TST_ONE) ? abd_pkg::OP_TEST_SKIP_IF_ONE :
              abd_pkg::OP_NO_OPERATION;

  // Operation classes
  wire is_add  = (op == abd_pkg::OP_ADD_LITERAL_TO_ACCUMULATOR) ||
                 (op == abd_pkg::OP_ADD_ACCUMULATOR_AND_FILE);
  wire is_and  = (op == abd_pkg::OP_AND_LITERAL_WITH_ACCUMULATOR) ||
                 (op == abd_pkg::OP_AND_ACCUMULATOR_WITH_FILE);
  wire is_lit  = (op == abd_pkg::OP_ADD_LITERAL_TO_ACCUMULATOR) ||
                 (op == abd_pkg::OP_AND_LITERAL_WITH_ACCUMULATOR);
  wire two_op  = (op == abd_pkg::OP_ADD_ACCUMULATOR_AND_FILE) ||
                 (op == abd_pkg::OP_AND_ACCUMULATOR_WITH_FILE);
  wire bit_rw  = (op == abd_pkg::OP_FILE_BIT_CLEAR) || (op == abd_pkg::OP_FILE_BIT_SET);

  // Arithmetic and logic
  wire [7:0] file_q   = mif.q;                            // File byte read in EX_READ
  wire [7:0] operand  = is_lit ? lit : file_q;
  wire [9:0] add_res  = add_flags(acc_r, operand);
  wire [7:0] and_res  = acc_r & operand;
  wire [7:0] alu_res  = is_add ? add_res[7:0] : and_res;
  wire [7:0] bmask    = bit_mask(bit_idx);
  // Whole byte goes back; only the chosen bit differs
  wire [7:0] rmw_res  = (op == abd_pkg::OP_FILE_BIT_SET) ? (file_q | bmask) :
                        (file_q & ~bmask);
  wire       tested   = |(file_q & bmask);
  wire       skip_take = ((op == abd_pkg::OP_TEST_SKIP_IF_ONE) && tested) ||
                         ((op == abd_pkg::OP_TEST_SKIP_IF_ZERO) && !tested);

  // Write-back steering in the second clock of the instruction
  wire in_write  = (ex_state_r == abd_pkg::EX_WRITE);
  wire ex_mem_we = in_write && ((two_op && dest_file) || bit_rw);
  wire acc_load  = in_write && (is_lit || (two_op && !dest_file));

  // Bus decode; requests wait while an instruction runs
  wire at_file   = (AVS_ADDRESS_I <= `ABD_FILE_LAST);
  wire at_acc    = (AVS_ADDRESS_I == `ABD_REG_ACC);
  wire at_status = (AVS_ADDRESS_I == `ABD_REG_STATUS);
  wire at_instr  = (AVS_ADDRESS_I == `ABD_REG_INSTR);
  wire ex_idle   = (ex_state_r == abd_pkg::EX_IDLE);
  wire bus_go    = (bus_state_r == abd_pkg::BUS_IDLE) && (AVS_READ_I || AVS_WRITE_I) && ex_idle;
  wire bus_wr    = bus_go && AVS_WRITE_I && AVS_BYTEENABLE_I[0];
  wire bus_mem_we = bus_wr && at_file;
  wire start_ex  = bus_wr && at_instr && AVS_BYTEENABLE_I[1];
  wire acc_wr    = bus_wr && at_acc;
  wire st_wr     = bus_wr && at_status;

  // Status word as software sees it
  wire [31:0] status_word = {27'h000_0000, last_skip_r, busy_r, z_r, dc_r, c_r};
  wire [31:0] reg_rdata   = at_acc    ? {24'h00_0000, acc_r} :
                            at_status ? status_word :
                            at_instr  ? {18'h0_0000, instr_r} :
                            `ABD_WORD_RST;

  // Memory port: bus owns it while idle, the instruction otherwise
  assign mif.addr  = ex_idle ? AVS_ADDRESS_I[`ABD_FADDR_W-1:0] : faddr;
  assign mif.wdata = ex_idle ? AVS_WRITEDATA_I[7:0] : (bit_rw ? rmw_res : alu_res);
  assign mif.we    = ex_mem_we || bus_mem_we;

  // Execution sequence: read, write, then an optional discarded slot
  always_comb begin
    ex_state_nxt = ex_state_r;
    case (ex_state_r)
      abd_pkg::EX_IDLE: begin
        if (start_ex) begin
          ex_state_nxt = abd_pkg::EX_READ;
        end
      end
      abd_pkg::EX_READ: begin
        ex_state_nxt = abd_pkg::EX_WRITE;
      end
      abd_pkg::EX_WRITE: begin
        ex_state_nxt = skip_take ? abd_pkg::EX_SKIP : abd_pkg::EX_IDLE;
      end
      default: begin
        // Discarded slot runs as no_operation for one more cycle
        if (skip_cnt_r == `ABD_SKIP_LAST) begin
          ex_state_nxt = abd_pkg::EX_IDLE;
        end
      end
    endcase
  end

  // Bus answer: writes and register reads one clock, file byte reads three clocks
  always_comb begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      abd_pkg::BUS_IDLE: begin
        if (bus_go) begin
          bus_state_nxt = (AVS_READ_I && at_file) ? abd_pkg::BUS_MEMRD : abd_pkg::BUS_ACK;
        end
      end
      abd_pkg::BUS_MEMRD: begin
        bus_state_nxt = abd_pkg::BUS_LOAD;
      end
      abd_pkg::BUS_LOAD: begin
        bus_state_nxt = abd_pkg::BUS_ACK;
      end
      default: begin
        bus_state_nxt = abd_pkg::BUS_IDLE;
      end
    endcase
  end

  // Sequencers and output flops
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ex_state_r  <= abd_pkg::EX_IDLE;
      bus_state_r <= abd_pkg::BUS_IDLE;
      skip_cnt_r  <= 1'b0;
      busy_r      <= 1'b0;
      waitreq_r   <= 1'b1;
      skip_r      <= 1'b0;
    end else begin
      ex_state_r  <= ex_state_nxt;
      bus_state_r <= bus_state_nxt;
      skip_cnt_r  <= (ex_state_r == abd_pkg::EX_SKIP) ? skip_cnt_r + 1'b1 : 1'b0;
      busy_r      <= (ex_state_nxt != abd_pkg::EX_IDLE);
      waitreq_r   <= (bus_state_nxt != abd_pkg::BUS_ACK);
      skip_r      <= in_write && skip_take;
    end
  end

  // Read data: register word at once, file byte after the RAM read
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      rdata_r <= `ABD_WORD_RST;
    end else if (bus_go && AVS_READ_I && !at_file) begin
      rdata_r <= reg_rdata;
    end else if (bus_state_r == abd_pkg::BUS_LOAD) begin
      rdata_r <= {24'h00_0000, file_q};
    end
  end

  // Instruction latch and discard record
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      instr_r     <= `ABD_INSTR_RST;
      last_skip_r <= 1'b0;
    end else if (start_ex) begin
      instr_r     <= AVS_WRITEDATA_I[`ABD_INSTR_W-1:0];
      last_skip_r <= 1'b0;
    end else if (in_write && skip_take) begin
      last_skip_r <= 1'b1;
    end
  end

  // Accumulator
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      acc_r <= `ABD_BYTE_RST;
    end else if (acc_wr) begin
      acc_r <= AVS_WRITEDATA_I[7:0];
    end else if (acc_load) begin
      acc_r <= alu_res;
    end
  end

  // Flags: adds touch all three, ANDs only Z, bit ops none
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      c_r  <= 1'b0;
      dc_r <= 1'b0;
      z_r  <= 1'b0;
    end else if (st_wr) begin
      c_r  <= AVS_WRITEDATA_I[`ABD_ST_C];
      dc_r <= AVS_WRITEDATA_I[`ABD_ST_DC];
      z_r  <= AVS_WRITEDATA_I[`ABD_ST_Z];
    end else if (in_write && is_add) begin
      c_r  <= add_res[`ABD_WORD_CARRY];
      dc_r <= add_res[`ABD_DC_POS];
      z_r  <= is_zero(add_res[7:0]);
    end else if (in_write && is_and) begin
      z_r  <= is_zero(and_res);
    end
  end

  assign AVS_READDATA_O    = rdata_r;
  assign AVS_WAITREQUEST_O = waitreq_r;
  assign BUSY_O            = busy_r;
  assign SKIP_O            = skip_r;

  // Checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_nop_slot;
    (ex_state_r == abd_pkg::EX_SKIP) [*2] ##1 (ex_state_r == abd_pkg::EX_IDLE);
  endsequence
  sequence s_one_hit;
    in_write && (op == abd_pkg::OP_TEST_SKIP_IF_ONE) && tested;
  endsequence
  sequence s_zero_hit;
    in_write && (op == abd_pkg::OP_TEST_SKIP_IF_ZERO) && !tested;
  endsequence

  property p_add_lit;
    (in_write && op == abd_pkg::OP_ADD_LITERAL_TO_ACCUMULATOR) |=>
      {c_r, acc_r} == 9'({1'b0, $past(acc_r)} + {1'b0, $past(lit)}) && z_r == (acc_r == 8'h00);
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("literal add wrong");

  property p_add_file;
    (in_write && op == abd_pkg::OP_ADD_ACCUMULATOR_AND_FILE && !dest_file) |=>
      {c_r, acc_r} == 9'({1'b0, $past(acc_r)} + {1'b0, $past(file_q)});
  endproperty
  a_add_file: assert property (p_add_file) else $error("file add wrong");

  property p_dest_file;
    (in_write && two_op && dest_file) |-> mif.we && mif.addr == faddr ##1 $stable(acc_r);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("destination wrong");

  property p_and_file;
    (in_write && op == abd_pkg::OP_AND_ACCUMULATOR_WITH_FILE) |=>
      $stable(c_r) && $stable(dc_r) && z_r == ($past(and_res) == 8'h00);
  endproperty
  a_and_file: assert property (p_and_file) else $error("file AND flags wrong");

  property p_and_lit;
    (in_write && op == abd_pkg::OP_AND_LITERAL_WITH_ACCUMULATOR) |=>
      acc_r == ($past(acc_r) & $past(lit)) && $stable(c_r) && $stable(dc_r);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("literal AND wrong");

  property p_bit_clear;
    (in_write && op == abd_pkg::OP_FILE_BIT_CLEAR) |->
      mif.we && !mif.wdata[bit_idx] ##1 $stable({c_r, dc_r, z_r});
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

  property p_bit_set;
    (in_write && op == abd_pkg::OP_FILE_BIT_SET) |->
      mif.we && mif.wdata[bit_idx] ##1 $stable({c_r, dc_r, z_r});
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

  property p_skip_one;
    s_one_hit |=> SKIP_O ##0 s_nop_slot;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip on one wrong");

  property p_skip_zero;
    s_zero_hit |=> SKIP_O && $stable({c_r, dc_r, z_r}) ##0 s_nop_slot;
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("skip on zero wrong");

  property p_rmw;
    (in_write && bit_rw) |-> mif.we && mif.addr == faddr && (mif.wdata ^ file_q) == (
      (op == abd_pkg::OP_FILE_BIT_SET) ? (bmask & ~file_q) : (bmask & file_q));
  endproperty
  a_rmw: assert property (p_rmw) else $error("byte write-back wrong");

endmodule

// file: rtl/abd_regs.svh
`ifndef ABD_REGS_SVH
`define ABD_REGS_SVH

// Avalon word addresses: file bytes first, then the control words
`define ABD_ADDR_W       8
`define ABD_FILE_LAST    8'h7f
`define ABD_FILE_DEPTH   128
`define ABD_FADDR_W      7
`define ABD_REG_ACC      8'h80
`define ABD_REG_STATUS   8'h81
`define ABD_REG_INSTR    8'h82

// Status word bit positions
`define ABD_ST_C         0
`define ABD_ST_DC        1
`define ABD_ST_Z         2
`define ABD_ST_BUSY      3
`define ABD_ST_SKIP      4

// Reset values
`define ABD_BYTE_RST     8'h00
`define ABD_INSTR_RST    14'h0000
`define ABD_WORD_RST     32'h0000_0000

// Instruction word fields
`define ABD_INSTR_W      14
`define ABD_LIT_F        7:0
`define ABD_FADDR_F      6:0
`define ABD_BIT_F        9:7
`define ABD_D_BIT        7
`define ABD_BYTEOP_F     13:8
`define ABD_BITOP_F      13:10
`define ABD_LITADD_F     13:9

// Opcode patterns
`define ABD_PAT_ADD_FILE 6'h07
`define ABD_PAT_AND_FILE 6'h05
`define ABD_PAT_AND_LIT  6'h39
`define ABD_PAT_ADD_LIT  5'h1f
`define ABD_PAT_BIT_CLR  4'h4
`define ABD_PAT_BIT_SET  4'h5
`define ABD_PAT_TST_ZERO 4'h6
`define ABD_PAT_TST_ONE  4'h7

// Adder carry positions
`define ABD_NIB_F        3:0
`define ABD_NIB_CARRY    4
`define ABD_WORD_CARRY   8
`define ABD_DC_POS       9

// Discarded slot lasts one instruction cycle of two clocks
`define ABD_SKIP_LAST    1'b1

`endif

// file: rtl/abd_pkg.sv
package abd_pkg;

  // Execution sequence, Gray coded along idle-read-write-skip
  typedef enum logic [1:0] {
    EX_IDLE  = 2'b00,
    EX_READ  = 2'b01,
    EX_WRITE = 2'b11,
    EX_SKIP  = 2'b10
  } abd_ex_state_t;

  // Bus answer sequence, Gray coded
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_MEMRD = 2'b01,
    BUS_LOAD  = 2'b11,
    BUS_ACK   = 2'b10
  } abd_bus_state_t;

  // Decoded operation kinds
  typedef enum logic [3:0] {
    OP_NO_OPERATION                 = 4'h0,
    OP_ADD_LITERAL_TO_ACCUMULATOR   = 4'h1,
    OP_ADD_ACCUMULATOR_AND_FILE     = 4'h2,
    OP_AND_LITERAL_WITH_ACCUMULATOR = 4'h3,
    OP_AND_ACCUMULATOR_WITH_FILE    = 4'h4,
    OP_FILE_BIT_CLEAR               = 4'h5,
    OP_FILE_BIT_SET                 = 4'h6,
    OP_TEST_SKIP_IF_ZERO            = 4'h7,
    OP_TEST_SKIP_IF_ONE             = 4'h8
  } abd_op_t;

endpackage

// file: rtl/abd_mem_if.sv
`timescale 1ns/1ps
`include "abd_regs.svh"
interface abd_mem_if;
  logic [`ABD_FADDR_W-1:0] addr;   // Byte address, read every clock
  logic [7:0]              wdata;  // Write byte
  logic                    we;     // Write strobe
  logic [7:0]              q;      // Registered read byte

  modport host (output addr, output wdata, output we, input q);
  modport mem  (input addr, input wdata, input we, output q);
endinterface

// file: rtl/abd_file_mem.sv
`timescale 1ns/1ps
`include "abd_regs.svh"
module abd_file_mem (
  input  wire logic clk_i,    // Core clock
  input  wire logic rst_n_i,  // Synchronous reset, active low
  abd_mem_if.mem    port_m    // Access port from the datapath
);
  logic [7:0] cells [0:`ABD_FILE_DEPTH-1];  // File byte array, no reset
  logic [7:0] q_r;                          // Read data register

  // Write port; array left unreset so it maps onto block RAM
  always_ff @(posedge clk_i) begin
    if (port_m.we) begin
      cells[port_m.addr] <= port_m.wdata;
    end
  end

  // Read every clock; a same-address write returns the old byte
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_r <= `ABD_BYTE_RST;
    end else begin
      q_r <= cells[port_m.addr];
    end
  end

  assign port_m.q = q_r;
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
`include "abd_regs.svh"
module tb;
  logic        clk;          // Core clock, 25 MHz
  logic        rst_n;        // Synchronous reset, active low
  logic [7:0]  avs_address;  // Bus word address
  logic        avs_read;     // Read request
  logic        avs_write;    // Write request
  logic [31:0] avs_wdata;    // Write data
  logic [3:0]  avs_be;       // Byte lanes
  logic [31:0] rdata;        // Bus read data
  logic        waitreq;      // Bus answer, low for one cycle
  logic        busy;         // Instruction running
  logic        skip;         // Discard pulse
  int          err_total;    // Mismatches seen
  int          n_checks;     // Comparisons made
  logic [31:0] q;            // Last read value
  logic [10:0] r;            // Adder reference {Z, DC, C, sum}
  logic [7:0]  m;            // One-hot bit mask
  logic [7:0]  fv;           // Tested file byte
  logic        z;            // Expected zero flag of an AND
  logic [7:0]  ta [5] = '{8'h00, 8'h0f, 8'hff, 8'h80, 8'h12};  // Accumulator operands
  logic [7:0]  tk [5] = '{8'h00, 8'h01, 8'h01, 8'h80, 8'hed};  // Second operands

  abd_datapath i_abd_datapath (
    .CLOCK_I           (clk),
    .RST_N_I           (rst_n),
    .AVS_ADDRESS_I     (avs_address),
    .AVS_READ_I        (avs_read),
    .AVS_WRITE_I       (avs_write),
    .AVS_WRITEDATA_I   (avs_wdata),
    .AVS_BYTEENABLE_I  (avs_be),
    .AVS_READDATA_O    (rdata),
    .AVS_WAITREQUEST_O (waitreq),
    .BUSY_O            (busy),
    .SKIP_O            (skip)
  );

  // Free-running clock, 40 ns period
  always #20 clk = ~clk;

  // Reference adder, kept apart from the design's own arithmetic
  function automatic logic [10:0] add_ref(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {(s[7:0] == 8'h00), n[4], s[8], s[7:0]};
  endfunction

  // Compare one value and keep the score
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask

  // Verdict and end of run
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One bus cycle; a clock edge always passes first, so a release never meets a new raise
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_read    <= ~wr;
    avs_write   <= wr;
    avs_wdata   <= d;
    avs_be      <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    rd = rdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (waitreq !== 1'b0) begin
      $display("BAD bus answer expected 0 seen %b", waitreq);
      err_total++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, {24'h000000, d}, 4'hf, dummy);
  endtask

  // Load operands, run one instruction, then check cycles, results and flags
  task automatic do_op(input logic [13:0] ins, input logic [6:0] fa, input logic [7:0] acc0,
                       input logic [7:0] f0, input logic [2:0] st0, input logic [7:0] e_acc,
                       input logic [7:0] e_f, input logic [2:0] e_st, input logic sk);
    int n;
    int s;
    logic [31:0] dummy;
    wr(`ABD_REG_ACC, acc0);
    wr({1'b0, fa}, f0);
    wr(`ABD_REG_STATUS, {5'h00, st0});
    bus(1'b1, `ABD_REG_INSTR, {18'h00000, ins}, 4'hf, dummy);
    n = 0;
    s = 0;
    // Busy cycles after the answer edge: one plain, three when the successor is discarded
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (busy === 1'b1) n++;
      if (skip === 1'b1) s++;
      if (busy !== 1'b1) break;
    end
    chk("busy cycles", n, sk ? 3 : 1);
    chk("skip pulses", s, {31'h0, sk});
    bus(1'b0, `ABD_REG_ACC, 32'h0, 4'hf, q);
    chk("accumulator", q, {24'h0, e_acc});
    bus(1'b0, {1'b0, fa}, 32'h0, 4'hf, q);
    chk("file byte", q, {24'h0, e_f});
    bus(1'b0, `ABD_REG_STATUS, 32'h0, 4'hf, q);
    chk("status", q, {27'h0, sk, 1'b0, e_st});
  endtask

  // Hang guard, far beyond the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    $display("BAD watchdog expected done seen hang");
    err_total++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_wdata = 32'h0;
    avs_be = 4'h0;
    err_total = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state of the control words
    bus(1'b0, `ABD_REG_ACC, 32'h0, 4'hf, q);
    chk("acc reset", q, 32'h0);
    bus(1'b0, `ABD_REG_STATUS, 32'h0, 4'hf, q);
    chk("status reset", q, 32'h0);
    bus(1'b0, `ABD_REG_INSTR, 32'h0, 4'hf, q);
    chk("instr reset", q, 32'h0);
    // Write without lane0 is ignored; unmapped read gives zero
    wr(`ABD_REG_ACC, 8'h55);
    bus(1'b1, `ABD_REG_ACC, 32'haa, 4'he, q);
    bus(1'b0, `ABD_REG_ACC, 32'h0, 4'hf, q);
    chk("acc lane guard", q, 32'h55);
    bus(1'b0, 8'h90, 32'h0, 4'hf, q);
    chk("unmapped read", q, 32'h0);
    $display("Test bus access done");
    // Adds: every flag starts inverted so each must really be written
    for (int i = 0; i < 5; i++) begin
      r = add_ref(ta[i], tk[i]);
      do_op({`ABD_PAT_ADD_LIT, i[0], tk[i]}, 7'h10, ta[i], 8'h3c, ~r[10:8],
            r[7:0], 8'h3c, r[10:8], 1'b0);
      do_op({`ABD_PAT_ADD_FILE, 1'b0, 7'h7f}, 7'h7f, ta[i], tk[i], ~r[10:8],
            r[7:0], tk[i], r[10:8], 1'b0);
      do_op({`ABD_PAT_ADD_FILE, 1'b1, 7'h00}, 7'h00, ta[i], tk[i], ~r[10:8],
            ta[i], r[7:0], r[10:8], 1'b0);
    end
    $display("Test add done");
    // ANDs: carry and nibble flags must survive
    for (int i = 0; i < 5; i++) begin
      z = ((ta[i] & tk[i]) == 8'h00);
      do_op({`ABD_PAT_AND_LIT, tk[i]}, 7'h10, ta[i], 8'h3c, {~z, i[0], ~i[0]},
            ta[i] & tk[i], 8'h3c, {z, i[0], ~i[0]}, 1'b0);
      do_op({`ABD_PAT_AND_FILE, 1'b0, 7'h7f}, 7'h7f, ta[i], tk[i], {~z, ~i[0], i[0]},
            ta[i] & tk[i], tk[i], {z, ~i[0], i[0]}, 1'b0);
      do_op({`ABD_PAT_AND_FILE, 1'b1, 7'h7f}, 7'h7f, ta[i], tk[i], {~z, i[0], i[0]},
            ta[i], ta[i] & tk[i], {z, i[0], i[0]}, 1'b0);
    end
    $display("Test and done");
    // Bit operations over every bit index, neighbours must keep their value
    for (int b = 0; b < 8; b++) begin
      m = 8'h01 << b;
      do_op({`ABD_PAT_BIT_CLR, b[2:0], 7'h7f}, 7'h7f, 8'h11, 8'hc3 | m, 3'b101,
            8'h11, 8'hc3 & ~m, 3'b101, 1'b0);
      do_op({`ABD_PAT_BIT_SET, b[2:0], 7'h00}, 7'h00, 8'h22, 8'h3c & ~m, 3'b010,
            8'h22, 8'h3c | m, 3'b010, 1'b0);
      for (int v = 0; v < 2; v++) begin
        fv = v[0] ? (8'h5a | m) : (8'h5a & ~m);
        do_op({`ABD_PAT_TST_ONE, b[2:0], 7'h7f}, 7'h7f, 8'h33, fv, 3'b110,
              8'h33, fv, 3'b110, v[0]);
        do_op({`ABD_PAT_TST_ZERO, b[2:0], 7'h00}, 7'h00, 8'h44, fv, 3'b001,
              8'h44, fv, 3'b001, ~v[0]);
      end
    end
    $display("Test bit operations done");
    complete_run();
  end
endmodule
